//--- htm_pkg.sv
// package of constants and types for the high-resolution time measurement flow block
//**********************************************************************
// Overview of operation
// - delay code 0..3 sets pulse-pair spacing (all four codes round up to one clock cycle)
// - one stop per channel per start in max-resolution mode
// - two stop channels share one start
// - max-resolution range up to 40 us
// - trigger after 400 ns in max-resolution mode, data within 1 us
// - same datapath as resolution-adjust mode
// - range bounded by the 16-bit time counter limit of 65535 cycles
// - quiet mode processes only on trigger
// - master reset clears state, inputs wait 40 ns
//**********************************************************************
package htm_pkg;
	localparam int CLK_PERIOD_PS = 10000;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MULT = 8'h04;
	localparam logic [7:0] OFF_CMD = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0C;
	localparam logic [7:0] OFF_RES1 = 8'h10;
	localparam logic [7:0] OFF_RES2 = 8'h14;
	// control register fields
	localparam int CTRL_SPEED_LSB = 0;
	localparam int CTRL_QUIET_BIT = 2;
	localparam int CTRL_MON_BIT = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [4:0] MULT_RESET = 5'h00;
	localparam logic [4:0] MULT_MAX = 5'h1F;
	// command register bits (write one to act)
	localparam int CMD_MRESET_BIT = 0;
	localparam int CMD_TRIG_BIT = 1;
	// times
	localparam int PP_BASE_PS = 5500;
	localparam int PP_STEP_PS = 1000;
	localparam int RST_HOLD_NS = 40;
	localparam int RST_HOLD_CYC = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TRIG_HOLD_NS = 400;
	localparam int TRIG_HOLD_CYC = (TRIG_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int VALID_MAX_NS = 1000;
	localparam int VALID_CYC = (VALID_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int MRANGE_NS = 40000;
	localparam int MRANGE_CYC = (MRANGE_NS * 1000) / CLK_PERIOD_PS;
	localparam int COARSE_MAX = 32767;
	localparam int BINS_PER_COARSE = 54;
	localparam logic [22:0] RESULT_MASK = 23'h7F_FFFF;
	localparam logic [31:0] OVERRANGE = 32'h0080_0000;
	localparam int CNT_W = 16;
	typedef enum logic [1:0] {
		HTM_IDLE = 2'b00,
		HTM_ARMED = 2'b01,
		HTM_WAIT = 2'b10,
		HTM_DONE = 2'b11
	} htm_state_t;
	typedef struct packed {
		logic [1:0] speed;
		logic quiet;
		logic mon;
	} htm_cfg_t;
endpackage

//--- htm_top.sv
// high-resolution time measurement control with apb register access
`timescale 1ns/1ps
module htm_top
	import htm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// measurement pins
	input wire logic start_in,
	input wire logic [1:0] stop_in,
	input wire logic [1:0] stop_input_disable_pin,
	input wire logic alu_trigger_in,
	// status pins
	output logic fifo1_empty_flag,
	output logic [1:0] result_valid
);
	//**********************************************************************
	// configuration and bus
	//**********************************************************************
	htm_cfg_t cfg_reg, cfg_next;
	logic [4:0] resolution_multiplier_reg, resolution_multiplier_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic mreset_cmd, sw_trig;
	logic wr_acc, rd_acc;
	logic max_res_mode;
	assign wr_acc = psel && penable && pwrite && !pready_reg;
	assign rd_acc = psel && penable && !pwrite && !pready_reg;
	assign max_res_mode = cfg_reg.mon && cfg_reg.quiet && (resolution_multiplier_reg == MULT_MAX);
	assign mreset_cmd = wr_acc && (paddr == OFF_CMD) && pwdata[CMD_MRESET_BIT];
	assign sw_trig = wr_acc && (paddr == OFF_CMD) && pwdata[CMD_TRIG_BIT];
	//**********************************************************************
	// measurement state
	//**********************************************************************
	htm_state_t state_reg, state_next;
	logic [CNT_W-1:0] time_reg, time_next;
	logic [CNT_W-1:0] holdoff_reg, holdoff_next;
	logic [CNT_W-1:0] spacing_reg, spacing_next;
	logic [CNT_W-1:0] since_stop_reg, since_stop_next;
	logic [CNT_W-1:0] valid_cnt_reg, valid_cnt_next;
	logic [1:0] hit_reg, hit_next;
	logic [31:0] raw_reg [2];
	logic [31:0] raw_next [2];
	logic [31:0] result_reg [2];
	logic [31:0] result_next [2];
	logic [1:0] result_valid_reg, result_valid_next;
	logic start_d_reg, trig_d_reg;
	logic [1:0] stop_d_reg;
	logic [CNT_W-1:0] pp_cyc;
	logic [CNT_W-1:0] range_cyc;
	logic accept, trig_edge, process_go;
	logic [1:0] stop_edge;
	// base plus extra edge-path delay rounds up to one cycle of minimum spacing for every delay code
	assign pp_cyc = CNT_W'((PP_BASE_PS + PP_STEP_PS * int'(cfg_reg.speed) + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS);
	assign range_cyc = max_res_mode ? CNT_W'(MRANGE_CYC) : {CNT_W{1'b1}};
	assign accept = (holdoff_reg == '0);
	assign trig_edge = alu_trigger_in && !trig_d_reg;
	// quiet processing only on trigger, and in max resolution not too soon after the last stop
	assign process_go = (trig_edge || sw_trig) && cfg_reg.quiet
		&& (!max_res_mode || since_stop_reg >= CNT_W'(TRIG_HOLD_CYC - 1));
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_edge
			assign stop_edge[gi] = stop_in[gi] && !stop_d_reg[gi] && !stop_input_disable_pin[gi];
		end
	endgenerate
	always_comb
	begin
		cfg_next = cfg_reg;
		resolution_multiplier_next = resolution_multiplier_reg;
		prdata_next = prdata_reg;
		pready_next = psel && penable && !pready_reg;
		pslverr_next = 1'b0;
		if (wr_acc)
		begin
			unique case (paddr)
				OFF_CTRL:
				begin
					cfg_next.speed = pwdata[CTRL_SPEED_LSB +: 2];
					cfg_next.quiet = pwdata[CTRL_QUIET_BIT];
					cfg_next.mon = pwdata[CTRL_MON_BIT];
				end
				OFF_MULT: resolution_multiplier_next = pwdata[4:0];
				OFF_CMD: ;
				default: pslverr_next = 1'b1;
			endcase
		end
		if (rd_acc)
		begin
			unique case (paddr)
				OFF_CTRL: prdata_next = {28'h000_0000, cfg_reg.mon, cfg_reg.quiet, cfg_reg.speed};
				OFF_MULT: prdata_next = {27'h000_0000, resolution_multiplier_reg};
				OFF_CMD: prdata_next = 32'h0000_0000;
				OFF_STAT: prdata_next = {26'h000_0000, max_res_mode, result_valid_reg, hit_reg, accept};
				OFF_RES1: prdata_next = result_reg[0];
				OFF_RES2: prdata_next = result_reg[1];
				default:
				begin
					prdata_next = 32'h0000_0000;
					pslverr_next = 1'b1;
				end
			endcase
		end
	end
	always_comb
	begin
		state_next = state_reg;
		time_next = time_reg;
		hit_next = hit_reg;
		raw_next = raw_reg;
		result_next = result_reg;
		result_valid_next = result_valid_reg;
		holdoff_next = (holdoff_reg != '0) ? holdoff_reg - 1'b1 : holdoff_reg;
		spacing_next = (spacing_reg != '0) ? spacing_reg - 1'b1 : spacing_reg;
		since_stop_next = (since_stop_reg != {CNT_W{1'b1}}) ? since_stop_reg + 1'b1 : since_stop_reg;
		valid_cnt_next = valid_cnt_reg;
		unique case (state_reg)
			HTM_IDLE:
			begin
				if (accept && start_in && !start_d_reg)
				begin
					state_next = HTM_ARMED;
					time_next = '0;
				end
			end
			HTM_ARMED:
			begin
				if (time_reg != range_cyc)
				begin
					time_next = time_reg + 1'b1;
				end
				for (int i = 0; i < 2; i++)
				begin
					// one hit per channel in max resolution; else spacing-limited multi-hit
					if (stop_edge[i] && accept && spacing_reg == '0 && !(max_res_mode && hit_reg[i]))
					begin
						hit_next[i] = 1'b1;
						raw_next[i] = (time_reg == range_cyc) ? OVERRANGE : {16'h0000, time_reg};
						spacing_next = pp_cyc;
						since_stop_next = '0;
					end
				end
				if (!cfg_reg.quiet && hit_reg != 2'b00)
				begin
					// non-quiet: processing runs after every event
					result_next = raw_reg;
					result_valid_next = hit_reg;
				end
				if (process_go)
				begin
					state_next = HTM_WAIT;
					valid_cnt_next = '0;
				end
			end
			HTM_WAIT:
			begin
				valid_cnt_next = valid_cnt_reg + 1'b1;
				if (valid_cnt_reg == CNT_W'(VALID_CYC - 1))
				begin
					// results valid inside the trigger-to-data limit
					// over-range marker in bit 23 is kept; the host masks it off
					result_next = raw_reg;
					result_valid_next = hit_reg;
					state_next = HTM_DONE;
				end
			end
			HTM_DONE: ;
		endcase
		if (mreset_cmd)
		begin
			// clear state, time, hits and results; configuration and the spacing, since-stop and valid counters are kept
			state_next = HTM_IDLE;
			hit_next = 2'b00;
			raw_next[0] = '0;
			raw_next[1] = '0;
			result_next[0] = '0;
			result_next[1] = '0;
			result_valid_next = 2'b00;
			time_next = '0;
			holdoff_next = CNT_W'(RST_HOLD_CYC);
		end
	end
	//**********************************************************************
	// registers
	//**********************************************************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg_reg <= htm_cfg_t'(4'h0);
			resolution_multiplier_reg <= MULT_RESET;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			state_reg <= HTM_IDLE;
			time_reg <= '0;
			holdoff_reg <= CNT_W'(RST_HOLD_CYC);
			spacing_reg <= '0;
			since_stop_reg <= '0;
			valid_cnt_reg <= '0;
			hit_reg <= 2'b00;
			raw_reg[0] <= '0;
			raw_reg[1] <= '0;
			result_reg[0] <= '0;
			result_reg[1] <= '0;
			result_valid_reg <= 2'b00;
			start_d_reg <= 1'b0;
			stop_d_reg <= 2'b00;
			trig_d_reg <= 1'b0;
			fifo1_empty_flag <= 1'b1;
			result_valid <= 2'b00;
		end
		else
		begin
			cfg_reg <= cfg_next;
			resolution_multiplier_reg <= resolution_multiplier_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			state_reg <= state_next;
			time_reg <= time_next;
			holdoff_reg <= holdoff_next;
			spacing_reg <= spacing_next;
			since_stop_reg <= since_stop_next;
			valid_cnt_reg <= valid_cnt_next;
			hit_reg <= hit_next;
			raw_reg <= raw_next;
			result_reg <= result_next;
			result_valid_reg <= result_valid_next;
			start_d_reg <= start_in;
			stop_d_reg <= stop_in;
			trig_d_reg <= alu_trigger_in;
			fifo1_empty_flag <= !result_valid_next[0];
			result_valid <= result_valid_next;
		end
	end
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
endmodule // htm_top

//--- htm_checker.sv
// assertion checker for the time measurement block
`timescale 1ns/1ps
module htm_checker
	import htm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// status
	input wire logic fifo1_empty_flag,
	input wire logic [1:0] result_valid
);
	//****
	// properties
	//****
	default clocking dc @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic rd = pready && !pwrite;
	wire logic mr = pready && pwrite && paddr == OFF_CMD && pwdata[CMD_MRESET_BIT];
	chk_ready_after_access: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	chk_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	chk_unmapped_read_zero: assert property (rd && pslverr |-> prdata == 32'h0000_0000)
		else $error("unmapped read data");
	chk_cmd_reads_zero: assert property (rd && paddr == OFF_CMD |-> prdata == 32'h0000_0000)
		else $error("command read data");
	chk_mult_field_width: assert property (rd && paddr == OFF_MULT |-> prdata[31:5] == '0)
		else $error("multiplier width");
	chk_ctrl_field_width: assert property (rd && paddr == OFF_CTRL |-> prdata[31:4] == '0)
		else $error("control width");
	chk_empty_tracks_valid: assert property (fifo1_empty_flag == !result_valid[0])
		else $error("empty flag wrong");
	chk_clear_by_reset: assert property ($fell(result_valid[0]) |-> mr || $past(mr))
		else $error("result lost");
	cover property (mr);
	cover property ($rose(result_valid[0]));
	cover property (pready && pslverr);
endmodule // htm_checker
bind htm_top htm_checker htm_checker_i (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .fifo1_empty_flag, .result_valid);

//--- htm_host.sv
// host model driving the apb register bus
`timescale 1ns/1ps
module htm_host
(
	// clock
	input wire logic clk,
	// apb master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	//****
	// transfers
	//****
	logic [31:0] rdata;
	logic err;
	initial
		{psel, penable, pwrite, paddr, pwdata} = '0;
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		@(posedge clk);
	endtask
endmodule // htm_host

//--- htm_top_bench.sv
// self-checking testbench for the time measurement block
`timescale 1ns/1ps
module htm_top_bench
	import htm_pkg::*;
;
	//****
	// harness
	//****
	logic clk, resetn, start_in, alu_trigger_in, psel, penable, pwrite, pready, pslverr, fifo1_empty_flag;
	logic [1:0] stop_in, stop_input_disable_pin, result_valid;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	int n_errors, n_compared, n;
	htm_top htm_top_i (
		.clk(clk),
		.resetn(resetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.start_in(start_in),
		.stop_in(stop_in),
		.stop_input_disable_pin(stop_input_disable_pin),
		.alu_trigger_in(alu_trigger_in),
		.fifo1_empty_flag(fifo1_empty_flag),
		.result_valid(result_valid)
	);
	htm_host htm_host_i (
		.clk(clk),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		htm_host_i.xfer(1'b0, a, 32'h0000_0000);
		chk(nm, e, htm_host_i.rdata);
	endtask
	task hit(input logic [3:0] m);
		{alu_trigger_in, start_in, stop_in} <= m;
		@(posedge clk) {alu_trigger_in, start_in, stop_in} <= 4'h0;
		@(posedge clk);
	endtask
	task setup(input logic [31:0] ctrl, input logic [4:0] mult);
		stop_input_disable_pin <= 2'b11;
		htm_host_i.xfer(1'b1, OFF_CTRL, ctrl);
		htm_host_i.xfer(1'b1, OFF_MULT, {27'h000_0000, mult});
		htm_host_i.xfer(1'b1, OFF_CMD, 32'h0000_0001);
		stop_input_disable_pin <= 2'b00;
		cyc(RST_HOLD_CYC + 1);
	endtask
	task wrap_up;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	//****
	// scenarios
	//****
	task t_regs;
		rd(OFF_CTRL, CTRL_RESET, "ctrl reset");
		rd(OFF_MULT, 32'h0000_0000, "mult reset");
		for (int c = 0; c < 4; c++)
		begin
			htm_host_i.xfer(1'b1, OFF_CTRL, c);
			rd(OFF_CTRL, c, "delay code");
		end
		htm_host_i.xfer(1'b1, OFF_MULT, 32'hFFFF_FFFF);
		rd(OFF_MULT, {27'h000_0000, MULT_MAX}, "mult field");
		htm_host_i.xfer(1'b1, 8'h18, 32'h0000_000F);
		chk("unmapped write", 1, htm_host_i.err);
		rd(8'h18, 32'h0000_0000, "unmapped read");
	endtask
	task t_nonquiet;
		setup(32'h0000_0000, 5'h00);
		hit(4'b0100);
		cyc(7);
		stop_input_disable_pin <= 2'b10;
		hit(4'b0011);
		cyc(1);
		chk("hit valid", 2'b01, result_valid);
		chk("empty flag", 0, fifo1_empty_flag);
		htm_host_i.xfer(1'b0, OFF_RES1, 32'h0000_0000);
		chk("hit time", 1, htm_host_i.rdata >= 8 && htm_host_i.rdata <= 10);
	endtask
	task t_maxres;
		setup(32'h0000_000C, MULT_MAX);
		rd(OFF_STAT, 32'h0000_0021, "mode active");
		hit(4'b0100);
		cyc(8);
		hit(4'b0001);
		cyc(8);
		hit(4'b0001);
		cyc(20);
		hit(4'b1000);
		cyc(110);
		chk("early trigger", 2'b00, result_valid);
		cyc(4000);
		hit(4'b0010);
		cyc(TRIG_HOLD_CYC - 2);
		hit(4'b1000);
		n = 0;
		while (result_valid !== 2'b11 && n < VALID_CYC + 4)
		begin
			cyc(1);
			n++;
		end
		chk("data in time", 1, n <= VALID_CYC + 1);
		htm_host_i.xfer(1'b0, OFF_RES1, 32'h0000_0000);
		n = int'(htm_host_i.rdata & {9'h000, RESULT_MASK});
		chk("first stop", 1, n >= 9 && n <= 11);
		rd(OFF_RES2, OVERRANGE, "over range");
		htm_host_i.xfer(1'b1, OFF_CMD, 32'h0000_0001);
		cyc(2);
		chk("cleared", 2'b00, result_valid);
		rd(OFF_CTRL, 32'h0000_000C, "ctrl kept");
	endtask
	task t_modes;
		setup(32'h0000_0008, MULT_MAX);
		rd(OFF_STAT, 32'h0000_0001, "no quiet");
		setup(32'h0000_000C, 5'h1E);
		rd(OFF_STAT, 32'h0000_0001, "mult 30");
	endtask
	initial
	begin
		{resetn, start_in, stop_in, stop_input_disable_pin, alu_trigger_in} = '0;
		cyc(10);
		resetn <= 1'b1;
		cyc(1);
		t_regs;
		t_nonquiet;
		t_maxres;
		t_modes;
		wrap_up;
	end
	initial
	begin
		#200_000;
		n_errors++;
		wrap_up;
	end
endmodule // htm_top_bench
